/* liu_cfg_consts.vh */
// register offsets, field positions and timing constants for the config bank
`ifndef LIU_CFG_CONSTS_VH
`define LIU_CFG_CONSTS_VH
`define ADDR_GLB_LO 6'h0F
`define ADDR_PTR_LO 6'h10
`define ADDR_TPL_LO 6'h11
`define ADDR_GLB_HI 6'h2F
`define ADDR_PTR_HI 6'h30
`define ADDR_TPL_HI 6'h31
`define BANK_INDIV 8'h01
`define RST_BYTE 8'h00
`define GLB_MATCH_MODE 7
`define GLB_AIS_LOSS 6
`define GLB_SHORT_OFF 5
`define GLB_CODE 4
`define GLB_DEPTH 3
`define GLB_CAL 2
`define GLB_POS 1
`define GLB_ENA 0
`define PTR_BW_HI 7
`define PTR_BW_LO 6
`define PTR_HITLESS 5
`define PTR_CH_HI 2
`define TPL_MATCH_ON 7
`define TPL_TX_TERM_OFF 6
`define TPL_IMP_SEL 3
`define TPL_MASK 8'hCF
`define PTR_MASK 8'hE7
`define LEVEL4_CAL_BIT 4
`define CLK_MHZ 25
`define ARM_WAIT_US 5
`define CAL_CYCLES 16'h0040
`define DEPTH_FULL 8'h80
`endif

/* liu_half_ctrl.v */
// one half of the line interface: resolves global overrides per channel
`timescale 1ns/1ps
module liu_half_ctrl #(
    parameter NCH = 8
) (
    input wire mclk,
    input wire reset_n,
    input wire [7:0] glb,
    input wire [7:0] ptr,
    input wire [8*NCH-1:0] tpl,
    input wire oe_pin,
    input wire [NCH-1:0] ch_short_off,
    input wire [NCH-1:0] ch_line_code,
    input wire [NCH-1:0] ch_depth_full,
    input wire [NCH-1:0] ch_attn_pos,
    input wire [NCH-1:0] ch_attn_en,
    input wire [NCH-1:0] ch_alarm_loss,
    output reg [NCH-1:0] short_off_ff,
    output reg [NCH-1:0] ami_ff,
    output reg [NCH-1:0] depth128_ff,
    output reg [NCH-1:0] attn_rx_ff,
    output reg [NCH-1:0] attn_en_ff,
    output reg [NCH-1:0] alarm_loss_ff,
    output reg [NCH-1:0] rx_match_ff,
    output reg [NCH-1:0] rx_full_int_ff,
    output reg [NCH-1:0] tx_term_off_ff,
    output reg [NCH-1:0] imp_sel_ff
);
`include "liu_cfg_consts.vh"

reg [NCH-1:0] nxt_rx_match;
reg [NCH-1:0] nxt_attn_rx;
integer i;
integer j;

////////////////////////////////////////////////////////////////////////////
// receive match and attenuator position per channel
always @* begin
    for (i = 0; i < NCH; i = i + 1) begin
        if (ptr[`PTR_HITLESS])
            nxt_rx_match[i] = oe_pin;
        else
            nxt_rx_match[i] = tpl[8*i+`TPL_MATCH_ON];
        if (glb[`GLB_ENA] | glb[`GLB_POS])
            nxt_attn_rx[i] = glb[`GLB_POS];
        else
            nxt_attn_rx[i] = ch_attn_pos[i];
    end
end

////////////////////////////////////////////////////////////////////////////
// registered per-channel controls
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        short_off_ff <= {NCH{1'b0}};
        ami_ff <= {NCH{1'b0}};
        depth128_ff <= {NCH{1'b0}};
        attn_rx_ff <= {NCH{1'b0}};
        attn_en_ff <= {NCH{1'b0}};
        alarm_loss_ff <= {NCH{1'b0}};
        rx_match_ff <= {NCH{1'b0}};
        rx_full_int_ff <= {NCH{1'b0}};
        tx_term_off_ff <= {NCH{1'b0}};
        imp_sel_ff <= {NCH{1'b0}};
    end else begin
        short_off_ff <= {NCH{glb[`GLB_SHORT_OFF]}} | ch_short_off;
        ami_ff <= {NCH{glb[`GLB_CODE]}} | ch_line_code;
        depth128_ff <= {NCH{glb[`GLB_DEPTH]}} | ch_depth_full;
        attn_rx_ff <= nxt_attn_rx;
        attn_en_ff <= {NCH{glb[`GLB_ENA]}} | ch_attn_en;
        alarm_loss_ff <= {NCH{glb[`GLB_AIS_LOSS]}} | ch_alarm_loss;
        rx_match_ff <= nxt_rx_match;
        // fully internal only when the match is on at all
        rx_full_int_ff <= nxt_rx_match & {NCH{glb[`GLB_MATCH_MODE]}};
        for (j = 0; j < NCH; j = j + 1) begin
            tx_term_off_ff[j] <= tpl[8*j+`TPL_TX_TERM_OFF];
            imp_sel_ff[j] <= tpl[8*j+`TPL_IMP_SEL];
        end
    end
end

endmodule // liu_half_ctrl

/* liu_global_cfg.v */
// global config, channel pointer and indirect template registers
`timescale 1ns/1ps
module liu_global_cfg #(
    parameter NCH = 8,
    parameter CAL_CYCLES = 16'h0040
) (
    input wire mclk,
    input wire reset_n,
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] bank_sel_lo,
    input wire [7:0] bank_sel_hi,
    input wire oe_pin,
    input wire [2*NCH-1:0] ch_short_off,
    input wire [2*NCH-1:0] ch_line_code,
    input wire [2*NCH-1:0] ch_depth_full,
    input wire [2*NCH-1:0] ch_attn_pos,
    input wire [2*NCH-1:0] ch_attn_en,
    input wire [2*NCH-1:0] ch_alarm_loss,
    output reg [7:0] reg_rdata_ff,
    output reg cal_busy_ff,
    output reg cal_start_ff,
    output reg [1:0] attn_bw_lo_ff,
    output reg [1:0] attn_bw_hi_ff,
    output reg [2*NCH-1:0] short_off_ff,
    output reg [2*NCH-1:0] ami_ff,
    output reg [2*NCH-1:0] depth128_ff,
    output reg [2*NCH-1:0] attn_rx_ff,
    output reg [2*NCH-1:0] attn_en_ff,
    output reg [2*NCH-1:0] alarm_loss_ff,
    output reg [2*NCH-1:0] rx_match_ff,
    output reg [2*NCH-1:0] rx_full_int_ff,
    output reg [2*NCH-1:0] tx_term_off_ff,
    output reg [2*NCH-1:0] imp_sel_ff
);
`include "liu_cfg_consts.vh"

////////////////////////////////////////////////////////////////////////////
// register storage
reg [7:0] glb_lo_ff;
reg [7:0] glb_hi_ff;
reg [7:0] ptr_lo_ff;
reg [7:0] ptr_hi_ff;
reg [7:0] tpl_ff [0:2*NCH-1];
reg [15:0] cal_cnt_ff;
reg [7:0] nxt_rdata;
wire [2:0] sel_lo;
wire [2:0] sel_hi;
wire [3:0] idx_lo;
wire [3:0] idx_hi;
wire wr_glb_lo;
wire cal_rise;
wire indiv_lo;
wire [8*NCH-1:0] tpl_lo_flat;
wire [8*NCH-1:0] tpl_hi_flat;
wire [NCH-1:0] h_short_lo, h_short_hi, h_ami_lo, h_ami_hi;
wire [NCH-1:0] h_dep_lo, h_dep_hi, h_arx_lo, h_arx_hi;
wire [NCH-1:0] h_aen_lo, h_aen_hi, h_al_lo, h_al_hi;
wire [NCH-1:0] h_rm_lo, h_rm_hi, h_rf_lo, h_rf_hi;
wire [NCH-1:0] h_to_lo, h_to_hi, h_is_lo, h_is_hi;
integer k;
genvar g;

// pointer picks channel within each half
assign sel_lo = ptr_lo_ff[`PTR_CH_HI:0];
assign sel_hi = ptr_hi_ff[`PTR_CH_HI:0];
assign idx_lo = {1'b0, sel_lo};
assign idx_hi = {1'b1, sel_hi};
assign indiv_lo = (bank_sel_lo == `BANK_INDIV);
// the lower global register is hidden while the individual bank is open
assign wr_glb_lo = reg_wr && !indiv_lo && (reg_addr == `ADDR_GLB_LO);
// rising write of start bit, only when armed in the upper register
assign cal_rise = wr_glb_lo && reg_wdata[`GLB_CAL] &&
    !glb_lo_ff[`GLB_CAL] && glb_hi_ff[`GLB_CAL];

////////////////////////////////////////////////////////////////////////////
// lower global register, hidden while the individual bank is open
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        glb_lo_ff <= `RST_BYTE;
    else if (wr_glb_lo)
        glb_lo_ff <= reg_wdata;
end

// upper global register, also holds the calibration arm bit
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        glb_hi_ff <= `RST_BYTE;
    else if (reg_wr && (reg_addr == `ADDR_GLB_HI))
        glb_hi_ff <= reg_wdata;
end

// channel pointers, unused bits kept at zero
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        ptr_lo_ff <= `RST_BYTE;
        ptr_hi_ff <= `RST_BYTE;
    end else if (reg_wr) begin
        if (reg_addr == `ADDR_PTR_LO)
            ptr_lo_ff <= reg_wdata & `PTR_MASK;
        if (reg_addr == `ADDR_PTR_HI)
            ptr_hi_ff <= reg_wdata & `PTR_MASK;
    end
end

// template store, only the pointed channel takes a write
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        for (k = 0; k < 2*NCH; k = k + 1)
            tpl_ff[k] <= `RST_BYTE;
    end else if (reg_wr) begin
        if (reg_addr == `ADDR_TPL_LO)
            tpl_ff[idx_lo] <= reg_wdata & `TPL_MASK;
        if (reg_addr == `ADDR_TPL_HI)
            tpl_ff[idx_hi] <= reg_wdata & `TPL_MASK;
    end
end

////////////////////////////////////////////////////////////////////////////
// calibration cycle shared by all sixteen channels
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        cal_cnt_ff <= 16'h0000;
        cal_busy_ff <= 1'b0;
        cal_start_ff <= 1'b0;
    end else begin
        cal_start_ff <= cal_rise;
        if (cal_rise) begin
            cal_cnt_ff <= CAL_CYCLES;
            cal_busy_ff <= 1'b1;
        end else if (cal_cnt_ff != 16'h0000) begin
            cal_cnt_ff <= cal_cnt_ff - 16'h0001;
            cal_busy_ff <= (cal_cnt_ff != 16'h0001);
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// read mux
always @* begin
    nxt_rdata = `RST_BYTE;
    case (reg_addr)
        `ADDR_GLB_LO: begin
            if (indiv_lo) begin
                // status only valid while start bit stays set
                nxt_rdata[`LEVEL4_CAL_BIT] =
                    glb_lo_ff[`GLB_CAL] & cal_busy_ff;
            end else begin
                nxt_rdata = glb_lo_ff;
            end
        end
        `ADDR_GLB_HI: nxt_rdata = glb_hi_ff;
        `ADDR_PTR_LO: nxt_rdata = ptr_lo_ff;
        `ADDR_PTR_HI: nxt_rdata = ptr_hi_ff;
        `ADDR_TPL_LO: nxt_rdata = tpl_ff[idx_lo];
        `ADDR_TPL_HI: nxt_rdata = tpl_ff[idx_hi];
        default: nxt_rdata = `RST_BYTE;
    endcase
end

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        reg_rdata_ff <= `RST_BYTE;
    else if (reg_rd)
        reg_rdata_ff <= nxt_rdata;
end

////////////////////////////////////////////////////////////////////////////
// lower bandwidth code straight from its pointer register
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        attn_bw_lo_ff <= 2'b00;
    else
        attn_bw_lo_ff <= ptr_lo_ff[`PTR_BW_HI:`PTR_BW_LO];
end

// upper bandwidth code straight from its pointer register
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        attn_bw_hi_ff <= 2'b00;
    else
        attn_bw_hi_ff <= ptr_hi_ff[`PTR_BW_HI:`PTR_BW_LO];
end

////////////////////////////////////////////////////////////////////////////
// flatten templates for each half
generate
    for (g = 0; g < NCH; g = g + 1) begin : g_flat
        assign tpl_lo_flat[8*g+7:8*g] = tpl_ff[g];
        assign tpl_hi_flat[8*g+7:8*g] = tpl_ff[g+NCH];
    end
endgenerate

liu_half_ctrl #(.NCH(NCH)) u_lo (
    .mclk(mclk),
    .reset_n(reset_n),
    .glb(glb_lo_ff),
    .ptr(ptr_lo_ff),
    .tpl(tpl_lo_flat),
    .oe_pin(oe_pin),
    .ch_short_off(ch_short_off[NCH-1:0]),
    .ch_line_code(ch_line_code[NCH-1:0]),
    .ch_depth_full(ch_depth_full[NCH-1:0]),
    .ch_attn_pos(ch_attn_pos[NCH-1:0]),
    .ch_attn_en(ch_attn_en[NCH-1:0]),
    .ch_alarm_loss(ch_alarm_loss[NCH-1:0]),
    .short_off_ff(h_short_lo),
    .ami_ff(h_ami_lo),
    .depth128_ff(h_dep_lo),
    .attn_rx_ff(h_arx_lo),
    .attn_en_ff(h_aen_lo),
    .alarm_loss_ff(h_al_lo),
    .rx_match_ff(h_rm_lo),
    .rx_full_int_ff(h_rf_lo),
    .tx_term_off_ff(h_to_lo),
    .imp_sel_ff(h_is_lo)
);

liu_half_ctrl #(.NCH(NCH)) u_hi (
    .mclk(mclk),
    .reset_n(reset_n),
    .glb(glb_hi_ff),
    .ptr(ptr_hi_ff),
    .tpl(tpl_hi_flat),
    .oe_pin(oe_pin),
    .ch_short_off(ch_short_off[2*NCH-1:NCH]),
    .ch_line_code(ch_line_code[2*NCH-1:NCH]),
    .ch_depth_full(ch_depth_full[2*NCH-1:NCH]),
    .ch_attn_pos(ch_attn_pos[2*NCH-1:NCH]),
    .ch_attn_en(ch_attn_en[2*NCH-1:NCH]),
    .ch_alarm_loss(ch_alarm_loss[2*NCH-1:NCH]),
    .short_off_ff(h_short_hi),
    .ami_ff(h_ami_hi),
    .depth128_ff(h_dep_hi),
    .attn_rx_ff(h_arx_hi),
    .attn_en_ff(h_aen_hi),
    .alarm_loss_ff(h_al_hi),
    .rx_match_ff(h_rm_hi),
    .rx_full_int_ff(h_rf_hi),
    .tx_term_off_ff(h_to_hi),
    .imp_sel_ff(h_is_hi)
);

////////////////////////////////////////////////////////////////////////////
// output stage: short-circuit protection disable per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        short_off_ff <= {2*NCH{1'b0}};
    else
        short_off_ff <= {h_short_hi, h_short_lo};
end

// output stage: AMI line code per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        ami_ff <= {2*NCH{1'b0}};
    else
        ami_ff <= {h_ami_hi, h_ami_lo};
end

// output stage: deep attenuator fifo per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        depth128_ff <= {2*NCH{1'b0}};
    else
        depth128_ff <= {h_dep_hi, h_dep_lo};
end

// output stage: attenuator in receive path per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        attn_rx_ff <= {2*NCH{1'b0}};
    else
        attn_rx_ff <= {h_arx_hi, h_arx_lo};
end

// output stage: attenuator enable per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        attn_en_ff <= {2*NCH{1'b0}};
    else
        attn_en_ff <= {h_aen_hi, h_aen_lo};
end

// output stage: alarm on loss per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        alarm_loss_ff <= {2*NCH{1'b0}};
    else
        alarm_loss_ff <= {h_al_hi, h_al_lo};
end

// output stage: receive match on per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        rx_match_ff <= {2*NCH{1'b0}};
    else
        rx_match_ff <= {h_rm_hi, h_rm_lo};
end

// output stage: fully internal receive match per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        rx_full_int_ff <= {2*NCH{1'b0}};
    else
        rx_full_int_ff <= {h_rf_hi, h_rf_lo};
end

// output stage: transmit termination off per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        tx_term_off_ff <= {2*NCH{1'b0}};
    else
        tx_term_off_ff <= {h_to_hi, h_to_lo};
end

// output stage: impedance select per channel
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
        imp_sel_ff <= {2*NCH{1'b0}};
    else
        imp_sel_ff <= {h_is_hi, h_is_lo};
end

endmodule // liu_global_cfg

/* liu_cfg_assertions.sv */
// concurrent checks on the global config bank ports
`timescale 1ns/1ps
module liu_cfg_assertions #(
    parameter NCH = 8,
    parameter CAL_CYCLES = 16'h0040
) (
    input wire mclk,
    input wire reset_n,
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire [7:0] bank_sel_lo,
    input wire oe_pin,
    input wire [2*NCH-1:0] ch_short_off,
    input wire [2*NCH-1:0] ch_line_code,
    input wire [2*NCH-1:0] ch_depth_full,
    input wire [2*NCH-1:0] ch_attn_en,
    input wire [2*NCH-1:0] ch_alarm_loss,
    input wire cal_busy_ff,
    input wire cal_start_ff,
    input wire [1:0] attn_bw_lo_ff,
    input wire [1:0] attn_bw_hi_ff,
    input wire [2*NCH-1:0] short_off_ff,
    input wire [2*NCH-1:0] ami_ff,
    input wire [2*NCH-1:0] depth128_ff,
    input wire [2*NCH-1:0] attn_en_ff,
    input wire [2*NCH-1:0] alarm_loss_ff
);
reg [7:0] gl_ff, gh_ff, pl_ff, ph_ff;
reg [3:0] quiet_ff;
reg [15:0] busy_ff;
reg [10*NCH:0] in_q_ff;
wire [10*NCH:0] in_now = {ch_short_off, ch_line_code, ch_depth_full,
    ch_attn_en, ch_alarm_loss, oe_pin};
wire wr_cal = reg_wr && reg_addr == 6'h0F && bank_sel_lo != 8'h01
    && reg_wdata[2];
wire q = quiet_ff >= 4'h6;
// global override of one bit position across both halves
function [2*NCH-1:0] ovr(input integer b);
    ovr = {{NCH{gh_ff[b]}}, {NCH{gl_ff[b]}}};
endfunction
////////////////////////////////////////////////////////////////////////////
// shadow registers, settle counter and busy length counter
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        gl_ff <= 8'h00;
        gh_ff <= 8'h00;
        pl_ff <= 8'h00;
        ph_ff <= 8'h00;
        quiet_ff <= 4'h0;
        busy_ff <= 16'h0000;
        in_q_ff <= {(10*NCH+1){1'b0}};
    end else begin
        if (reg_wr && reg_addr == 6'h0F && bank_sel_lo != 8'h01) gl_ff <= reg_wdata;
        if (reg_wr && reg_addr == 6'h2F) gh_ff <= reg_wdata;
        if (reg_wr && reg_addr == 6'h10) pl_ff <= reg_wdata;
        if (reg_wr && reg_addr == 6'h30) ph_ff <= reg_wdata;
        in_q_ff <= in_now;
        if (reg_wr || in_now != in_q_ff) quiet_ff <= 4'h0;
        else if (!q) quiet_ff <= quiet_ff + 4'h1;
        busy_ff <= cal_busy_ff ? busy_ff + 16'h0001 : 16'h0000;
    end
end
a_cal_one_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    cal_start_ff |=> !cal_start_ff) else $error("start pulse too long");
a_cal_from_write: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(cal_start_ff) |-> $past(wr_cal) || $past(wr_cal, 2))
    else $error("start without rising write");
a_cal_needs_arm: assert property (@(posedge mclk) disable iff (!reset_n)
    cal_start_ff |-> gh_ff[2] && cal_busy_ff) else $error("start unarmed");
a_busy_length: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(cal_busy_ff) |-> busy_ff == CAL_CYCLES) else $error("busy length");
a_short_ovr: assert property (@(posedge mclk) disable iff (!reset_n)
    q |-> short_off_ff == (ch_short_off | ovr(5))) else $error("short off");
a_code_ovr: assert property (@(posedge mclk) disable iff (!reset_n)
    q |-> ami_ff == (ch_line_code | ovr(4))) else $error("line code");
a_depth_ovr: assert property (@(posedge mclk) disable iff (!reset_n)
    q |-> depth128_ff == (ch_depth_full | ovr(3))) else $error("depth");
a_attn_en_ovr: assert property (@(posedge mclk) disable iff (!reset_n)
    q |-> attn_en_ff == (ch_attn_en | ovr(0))) else $error("attn enable");
a_alarm_ovr: assert property (@(posedge mclk) disable iff (!reset_n)
    q |-> alarm_loss_ff == (ch_alarm_loss | ovr(6))) else $error("alarm");
a_bw_field: assert property (@(posedge mclk) disable iff (!reset_n)
    q |-> {attn_bw_hi_ff, attn_bw_lo_ff} == {ph_ff[7:6], pl_ff[7:6]})
    else $error("bandwidth field");
endmodule // liu_cfg_assertions

bind liu_global_cfg liu_cfg_assertions #(.NCH(NCH), .CAL_CYCLES(CAL_CYCLES))
    u_chk (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .bank_sel_lo,
    .oe_pin, .ch_short_off, .ch_line_code, .ch_depth_full, .ch_attn_en,
    .ch_alarm_loss, .cal_busy_ff, .cal_start_ff, .attn_bw_lo_ff,
    .attn_bw_hi_ff, .short_off_ff, .ami_ff, .depth128_ff, .attn_en_ff,
    .alarm_loss_ff);

/* test_liu_global_cfg.sv */
// self-checking bench for the global config bank
`timescale 1ns/1ps
module test_liu_global_cfg;
reg mclk, reset_n, reg_wr, reg_rd, oe_pin;
reg [5:0] reg_addr;
reg [7:0] reg_wdata, bank_sel_lo, bank_sel_hi;
reg [15:0] ch_short_off, ch_line_code, ch_depth_full, ch_attn_pos;
reg [15:0] ch_attn_en, ch_alarm_loss, m_on, t_off, i_sel;
wire [7:0] reg_rdata_ff;
wire cal_busy_ff, cal_start_ff;
wire [1:0] attn_bw_lo_ff, attn_bw_hi_ff;
wire [15:0] short_off_ff, ami_ff, depth128_ff, attn_rx_ff, attn_en_ff;
wire [15:0] alarm_loss_ff, rx_match_ff, rx_full_int_ff, tx_term_off_ff;
wire [15:0] imp_sel_ff;
integer fail_count, checks_done, cycles, starts, n;
reg [7:0] d;
reg [5:0] a;
liu_global_cfg #(.NCH(8), .CAL_CYCLES(16'h0010)) dut (.mclk, .reset_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .bank_sel_lo, .bank_sel_hi,
    .oe_pin, .ch_short_off, .ch_line_code, .ch_depth_full, .ch_attn_pos,
    .ch_attn_en, .ch_alarm_loss, .reg_rdata_ff, .cal_busy_ff, .cal_start_ff,
    .attn_bw_lo_ff, .attn_bw_hi_ff, .short_off_ff, .ami_ff, .depth128_ff,
    .attn_rx_ff, .attn_en_ff, .alarm_loss_ff, .rx_match_ff, .rx_full_int_ff,
    .tx_term_off_ff, .imp_sel_ff);
////////////////////////////////////////////////////////////////////////////
// compare, bus cycles and closing report
task check(input [15:0] seen, input [15:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
endtask
task idle(input integer c);
    begin
        repeat (c) @(posedge mclk);
        #1;
    end
endtask
task wr(input [5:0] ad, input [7:0] dt);
    begin
        @(posedge mclk);
        reg_addr <= ad;
        reg_wdata <= dt;
        reg_wr <= 1'h1;
        @(posedge mclk);
        reg_wr <= 1'h0;
    end
endtask
task rd(input [5:0] ad, input [7:0] exp);
    begin
        @(posedge mclk);
        reg_addr <= ad;
        reg_rd <= 1'h1;
        @(posedge mclk);
        reg_rd <= 1'h0;
        idle(1);
        check({8'h00, reg_rdata_ff}, {8'h00, exp});
    end
endtask
task summarize;
    begin
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    end
endtask
////////////////////////////////////////////////////////////////////////////
// reset values, pointer mask and unmapped place
task t_regs;
    begin
        rd(6'h0F, 8'h00);
        rd(6'h2F, 8'h00);
        rd(6'h11, 8'h00);
        rd(6'h31, 8'h00);
        wr(6'h05, 8'hFF);
        rd(6'h05, 8'h00);
        wr(6'h30, 8'hFF);
        rd(6'h30, 8'hE7);
        wr(6'h30, 8'h00);
    end
endtask
// one template per channel, read back through the pointer
task t_template;
    begin
        for (n = 0; n < 16; n = n + 1) begin
            a = (n < 8) ? 6'h10 : 6'h30;
            d = {n[0], n[1] ^ n[3], 2'h0, n[2] ^ n[3], n[2:0]};
            m_on[n] = d[7];
            t_off[n] = d[6];
            i_sel[n] = d[3];
            wr(a, {5'h00, n[2:0]});
            wr(a + 6'h01, d);
        end
        for (n = 15; n >= 0; n = n - 1) begin
            a = (n < 8) ? 6'h10 : 6'h30;
            wr(a, {5'h00, n[2:0]});
            rd(a + 6'h01, {n[0], n[1] ^ n[3], 2'h0, n[2] ^ n[3], n[2:0]});
        end
        idle(4);
        check(rx_match_ff, m_on);
        check(tx_term_off_ff, t_off);
        check(imp_sel_ff, i_sel);
        wr(6'h10, 8'h20);
        oe_pin <= 1'h1;
        idle(4);
        check(rx_match_ff, {m_on[15:8], 8'hFF});
        @(posedge mclk);
        oe_pin <= 1'h0;
        idle(4);
        check(rx_match_ff, {m_on[15:8], 8'h00});
        wr(6'h10, 8'h00);
        wr(6'h0F, 8'h80);
        idle(4);
        check(rx_full_int_ff, {8'h00, m_on[7:0]});
    end
endtask
// global overrides against fixed per-channel settings
task t_override(input [7:0] lo, input [7:0] hi);
    reg [15:0] ge, gp;
    begin
        wr(6'h0F, lo);
        wr(6'h2F, hi);
        idle(4);
        ge = {{8{hi[0] | hi[1]}}, {8{lo[0] | lo[1]}}};
        gp = {{8{hi[1]}}, {8{lo[1]}}};
        check(short_off_ff, ch_short_off | {{8{hi[5]}}, {8{lo[5]}}});
        check(ami_ff, ch_line_code | {{8{hi[4]}}, {8{lo[4]}}});
        check(depth128_ff, ch_depth_full | {{8{hi[3]}}, {8{lo[3]}}});
        check(alarm_loss_ff, ch_alarm_loss | {{8{hi[6]}}, {8{lo[6]}}});
        check(attn_en_ff, ch_attn_en | {{8{hi[0]}}, {8{lo[0]}}});
        check(attn_rx_ff, (ge & gp) | (~ge & ch_attn_pos));
    end
endtask
// bandwidth codes, all four in each half
task t_bw;
    begin
        for (n = 0; n < 4; n = n + 1) begin
            wr(6'h10, {n[1:0], 6'h00});
            wr(6'h30, {~n[1:0], 6'h00});
            idle(4);
            check({12'h000, attn_bw_hi_ff, attn_bw_lo_ff},
                {12'h000, ~n[1:0], n[1:0]});
        end
    end
endtask
// calibration: unarmed, armed, status read, level and new edge
task t_cal;
    begin
        wr(6'h0F, 8'h04);
        idle(30);
        check(starts[15:0], 16'h0000);
        wr(6'h0F, 8'h00);
        wr(6'h2F, 8'h04);
        idle(125);
        wr(6'h0F, 8'h04);
        @(posedge mclk);
        bank_sel_lo <= 8'h01;
        rd(6'h0F, 8'h10);
        n = 0;
        while (cal_busy_ff !== 1'h0 && n < 100) begin
            idle(1);
            n = n + 1;
        end
        rd(6'h0F, 8'h00);
        @(posedge mclk);
        bank_sel_lo <= 8'h00;
        wr(6'h0F, 8'h04);
        idle(30);
        check(starts[15:0], 16'h0001);
        wr(6'h0F, 8'h00);
        wr(6'h0F, 8'h04);
        idle(30);
        check(starts[15:0], 16'h0002);
    end
endtask
////////////////////////////////////////////////////////////////////////////
// clock, cycle ceiling and start pulse count
initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
end
always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cal_start_ff === 1'h1) starts = starts + 1;
    if (cycles == 20000) begin
        fail_count = fail_count + 1;
        summarize;
    end
end
// main sequence
initial begin
    {reset_n, reg_wr, reg_rd, oe_pin, reg_addr, reg_wdata} = 0;
    {bank_sel_lo, bank_sel_hi, fail_count, checks_done, cycles, starts} = 0;
    ch_short_off = 16'hA5C3;
    ch_line_code = 16'h3C5A;
    ch_depth_full = 16'h0FF0;
    ch_attn_pos = 16'h9669;
    ch_attn_en = 16'h1248;
    ch_alarm_loss = 16'h8421;
    repeat (12) @(posedge mclk);
    reset_n <= 1'h1;
    t_regs;
    t_template;
    t_override(8'h79, 8'h00);
    t_override(8'h00, 8'h7B);
    t_override(8'h02, 8'h01);
    t_override(8'h00, 8'h00);
    t_bw;
    t_cal;
    summarize;
end
endmodule // test_liu_global_cfg
